// File: rtsl_err_queue.sv
`timescale 1ns/1ps
module rtsl_err_queue (
	input  wire logic     aclk,    // System clock
	input  wire logic     aresetn, // Synchronous reset, active low
	rtsl_errq_if.queue    q        // Push, pop and head of the error queue
);
	import rtsl_pkg::*;

	logic [15:0]        mem_ff [ERRQ_DEPTH];
	logic [ERRQ_AW-1:0] wr_ptr_ff;
	logic [ERRQ_AW-1:0] rd_ptr_ff;
	logic [ERRQ_AW:0]   count_ff;
	logic               ovf_ff;
	logic               full;
	logic               do_pop;
	logic               do_push;

	assign full    = (count_ff == (ERRQ_AW+1)'(ERRQ_DEPTH));
	assign q.empty = (count_ff == '0);
	assign do_pop  = q.pop && !q.empty;
	assign do_push = q.push && (!full || do_pop);
	// Empty queue answers code 0
	assign q.head     = q.empty ? ERR_NONE : mem_ff[rd_ptr_ff];
	assign q.overflow = ovf_ff;

	always_ff @(posedge aclk) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= q.push_code;
		end else if (q.push && full) begin
			// Newest entry is overwritten so the loss is reported last
			mem_ff[wr_ptr_ff - 1'b1] <= ERR_OVERFLOW;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || q.flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
			ovf_ff    <= 1'b0;
		end else begin
			ovf_ff <= q.push && full && !do_pop;
			if (do_push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (do_push && !do_pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (do_pop && !do_push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

endmodule : rtsl_err_queue

// File: rtsl_errq_if.sv
`timescale 1ns/1ps
interface rtsl_errq_if;
	logic        push;
	logic [15:0] push_code;
	logic        pop;
	logic        flush;
	logic [15:0] head;
	logic        empty;
	logic        overflow;

	modport user (output push, output push_code, output pop, output flush,
		input head, input empty, input overflow);
	modport queue (input push, input push_code, input pop, input flush,
		output head, output empty, output overflow);
endinterface : rtsl_errq_if

// File: rtsl_host.sv
`timescale 1ns/1ps
module rtsl_host (
	output logic rx_line // Idles high
);
	initial rx_line = 1'b1;
	// 19200 baud, 8 data, no parity, 1 stop, no flow control
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			rx_line = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
			#52083;
		end
	endtask : send
endmodule : rtsl_host

// File: rtsl_pkg.sv
package rtsl_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_CONT      = 8'h04;
	localparam logic [7:0] OFF_IMM_CURR  = 8'h08;
	localparam logic [7:0] OFF_IMM_VOLT  = 8'h0C;
	localparam logic [7:0] OFF_PEND_CURR = 8'h10;
	localparam logic [7:0] OFF_PEND_VOLT = 8'h14;
	localparam logic [7:0] OFF_ACT_CURR  = 8'h18;
	localparam logic [7:0] OFF_ACT_VOLT  = 8'h1C;
	localparam logic [7:0] OFF_OPER      = 8'h20;
	localparam logic [7:0] OFF_ESR       = 8'h24;
	localparam logic [7:0] OFF_ESE       = 8'h28;
	localparam logic [7:0] OFF_SRE       = 8'h2C;
	localparam logic [7:0] OFF_STB       = 8'h30;
	localparam logic [7:0] OFF_ERR_POST  = 8'h34;
	localparam logic [7:0] OFF_ERR_READ  = 8'h38;
	localparam logic [7:0] OFF_PORT      = 8'h3C;

	// Command bits of the control register (write-one pulses)
	localparam int unsigned CTRL_ARM    = 0;
	localparam int unsigned CTRL_FIRE   = 1;
	localparam int unsigned CTRL_CANCEL = 2;
	localparam int unsigned CTRL_RECALL = 3;
	localparam int unsigned CTRL_RESET  = 4;
	localparam int unsigned CTRL_CLEAR  = 5;

	// Status bit positions
	localparam int unsigned OPER_WTG = 5;
	localparam int unsigned ESR_QYE  = 2;
	localparam int unsigned ESR_DDE  = 3;
	localparam int unsigned ESR_EXE  = 4;
	localparam int unsigned ESR_CME  = 5;
	localparam int unsigned ESR_PON  = 7;
	localparam int unsigned STB_MAV  = 4;
	localparam int unsigned STB_ESB  = 5;
	localparam int unsigned STB_MSS  = 6;

	localparam logic [7:0]  ESR_RESET  = 8'h80;
	localparam logic [15:0] OPER_RESET = 16'h0000;
	localparam logic [7:0]  MASK_RESET = 8'h00;
	localparam int unsigned LEVEL_W    = 16;

	// Error codes, 16-bit two's complement
	localparam logic [15:0] ERR_NONE     = 16'h0000;
	localparam logic [15:0] ERR_CMD      = 16'hFF9C;
	localparam logic [15:0] ERR_SYNTAX   = 16'hFF9A;
	localparam logic [15:0] ERR_PARAM    = 16'hFF94;
	localparam logic [15:0] ERR_RANGE    = 16'hFF22;
	localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;
	localparam logic [15:0] ERR_QUERY    = 16'hFE70;

	// Code range bounds: each class spans hi down to lo
	localparam logic [15:0] CME_HI = 16'hFF9C;
	localparam logic [15:0] CME_LO = 16'hFF39;
	localparam logic [15:0] EXE_HI = 16'hFF38;
	localparam logic [15:0] EXE_LO = 16'hFED5;
	localparam logic [15:0] DDE_HI = 16'hFED4;
	localparam logic [15:0] DDE_LO = 16'hFE71;
	localparam logic [15:0] QYE_HI = 16'hFE70;
	localparam logic [15:0] QYE_LO = 16'hFE0D;

	// Message string identifiers returned beside the code
	localparam logic [7:0] TXT_NONE     = 8'h00;
	localparam logic [7:0] TXT_CMD      = 8'h01;
	localparam logic [7:0] TXT_SYNTAX   = 8'h02;
	localparam logic [7:0] TXT_PARAM    = 8'h03;
	localparam logic [7:0] TXT_RANGE    = 8'h04;
	localparam logic [7:0] TXT_OVERFLOW = 8'h05;
	localparam logic [7:0] TXT_QUERY    = 8'h06;
	localparam logic [7:0] TXT_UNKNOWN  = 8'h07;

	localparam int unsigned ERRQ_DEPTH = 8;
	localparam int unsigned ERRQ_AW    = 3;

	// Serial link framing: 19200 baud, 8 data, no parity, 1 stop, no flow control
	localparam int unsigned CLK_HZ    = 100_000_000;
	localparam int unsigned BAUD      = 19200;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned STOP_BITS = 1;
	localparam logic [15:0] BAUD_DIV  = 16'(CLK_HZ / BAUD);

	// Port inactivity release time
	localparam int unsigned IDLE_MINUTES = 5;
	localparam logic [35:0] IDLE_CYC     = 36'(IDLE_MINUTES * 60) * 36'(CLK_HZ);

	typedef enum logic [1:0] {
		port_none,
		port_a,
		port_b
	} rtsl_port_t;

endpackage : rtsl_pkg

// File: rtsl_props.sv
`timescale 1ns/1ps
module rtsl_props (
	input logic        aclk,                     // Clock
	input logic        aresetn,                  // Reset
	input logic        s_axi_awready,            // Ready
	input logic        s_axi_bvalid,             // Answer
	input logic        s_axi_arvalid,            // Request
	input logic        s_axi_arready,            // Ready
	input logic        s_axi_rvalid,             // Answer
	input logic        s_axi_rready,             // Taken
	input logic        trigger_pulse,            // Trigger
	input logic        waiting_for_trigger_flag, // Waiting
	input logic [15:0] uart_baud_div,            // Divider
	input rtsl_pkg::rtsl_port_t port_active      // Port
);
	import rtsl_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
	a_read_answer: assert property (s_ar_take |=> s_axi_rvalid) else $error("read unanswered");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overtaken");
	a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("read dropped");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write overtaken");
	a_pulse_single: assert property (trigger_pulse |=> !trigger_pulse) else $error("long pulse");
	a_pulse_cause: assert property (trigger_pulse |-> s_axi_bvalid) else $error("stray pulse");
	a_reset_idle: assert property ($rose(aresetn) |-> !waiting_for_trigger_flag && port_active == port_none) else $error("not idle");
	a_baud_fixed: assert property ($past(aresetn) |-> uart_baud_div == BAUD_DIV) else $error("bad period");
endmodule : rtsl_props
bind rtsl_top rtsl_props u_props (.*);

// File: rtsl_top.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module rtsl_top #(
	parameter logic [35:0] IDLE_CYCLES = rtsl_pkg::IDLE_CYC // Port inactivity release, cycles
) (
	input  wire logic        aclk,                     // System clock, 100 MHz
	input  wire logic        aresetn,                  // Synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,             // Write address
	input  wire logic [2:0]  s_axi_awprot,             // Write protection, unused
	input  wire logic        s_axi_awvalid,            // Write address valid
	output logic             s_axi_awready,            // Write address ready
	input  wire logic [31:0] s_axi_wdata,              // Write data
	input  wire logic [3:0]  s_axi_wstrb,              // Write byte strobes
	input  wire logic        s_axi_wvalid,             // Write data valid
	output logic             s_axi_wready,             // Write data ready
	output logic [1:0]       s_axi_bresp,              // Write response
	output logic             s_axi_bvalid,             // Write response valid
	input  wire logic        s_axi_bready,             // Write response ready
	input  wire logic [7:0]  s_axi_araddr,             // Read address
	input  wire logic [2:0]  s_axi_arprot,             // Read protection, unused
	input  wire logic        s_axi_arvalid,            // Read address valid
	output logic             s_axi_arready,            // Read address ready
	output logic [31:0]      s_axi_rdata,              // Read data
	output logic [1:0]       s_axi_rresp,              // Read response
	output logic             s_axi_rvalid,             // Read data valid
	input  wire logic        s_axi_rready,             // Read data ready
	input  wire logic        rx_a,                     // Serial receive pin, port A
	input  wire logic        rx_b,                     // Serial receive pin, port B
	input  wire logic        msg_pending,              // Output buffer holds a message
	output logic [15:0]      active_current,           // Applied current level
	output logic [15:0]      active_voltage,           // Applied voltage level
	output logic             trigger_pulse,            // One-cycle internal trigger
	output logic             waiting_for_trigger_flag, // Armed and waiting
	output logic             service_summary_bit,      // Service request summary
	output rtsl_pkg::rtsl_port_t port_active,          // Selected command port
	output logic             rx_selected,              // Receive line of the active port
	output logic [15:0]      uart_baud_div             // Bit period for the receiver
);
	import rtsl_pkg::*;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= OFF_PORT);
	endfunction : is_mapped

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic [7:0] err_class(input logic [15:0] c);
		logic [7:0] m;
		m = 8'h00;
		if (c <= CME_HI && c >= CME_LO) m[ESR_CME] = 1'b1;
		if (c <= EXE_HI && c >= EXE_LO) m[ESR_EXE] = 1'b1;
		if (c <= DDE_HI && c >= DDE_LO) m[ESR_DDE] = 1'b1;
		if (c <= QYE_HI && c >= QYE_LO) m[ESR_QYE] = 1'b1;
		return m;
	endfunction : err_class

	function automatic logic [7:0] err_text(input logic [15:0] c);
		unique case (c)
			ERR_NONE:     return TXT_NONE;
			ERR_CMD:      return TXT_CMD;
			ERR_SYNTAX:   return TXT_SYNTAX;
			ERR_PARAM:    return TXT_PARAM;
			ERR_RANGE:    return TXT_RANGE;
			ERR_OVERFLOW: return TXT_OVERFLOW;
			ERR_QUERY:    return TXT_QUERY;
			default:      return TXT_UNKNOWN;
		endcase
	endfunction : err_text

	// AXI4-Lite slave state
	logic        aw_held_ff;
	logic [7:0]  awaddr_ff;
	logic        w_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        wr_fire;
	logic        rd_fire;
	logic [31:0] nxt_rdata;

	// Trigger and status state
	logic        armed_ff;
	logic        cont_ff;
	logic        pend_valid_ff;
	logic [15:0] oper_ff;
	logic        fire_trigger_cmd_pulse_ff;
	logic [15:0] imm_curr_ff;
	logic [15:0] imm_volt_ff;
	logic [15:0] pend_curr_ff;
	logic [15:0] pend_volt_ff;
	logic [15:0] act_curr_ff;
	logic [15:0] act_volt_ff;
	logic [7:0]  esr_ff;
	logic [7:0]  ese_ff;
	logic [7:0]  sre_ff;
	logic [7:0]  stb;
	logic        wr_ctrl;
	logic        cmd_arm;
	logic        cmd_fire;
	logic        cmd_abort;
	logic        cmd_clear;
	logic        fire_ok;
	logic        cont_on_write;
	logic [15:0] nxt_imm_curr;
	logic [15:0] nxt_imm_volt;

	// Port arbitration state
	logic [1:0]  rx_meta_ff;
	logic [1:0]  rx_sync_ff;
	logic [1:0]  rx_prev_ff;
	logic [1:0]  rx_start;
	rtsl_port_t  port_ff;
	logic [35:0] idle_cnt_ff;
	logic        rx_sel_ff;
	logic [15:0] baud_div_ff;

	rtsl_errq_if errq ();

	rtsl_err_queue u_err_queue (
		.aclk    (aclk),
		.aresetn (aresetn),
		.q       (errq.queue)
	);

	// ---------------- Register bus ----------------
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
	assign rd_fire       = s_axi_arvalid && !rvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			awaddr_ff  <= '0;
			w_held_ff  <= 1'b0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (s_axi_araddr)
			OFF_CONT:      nxt_rdata = {31'h0000_0000, cont_ff};
			OFF_IMM_CURR:  nxt_rdata = {16'h0000, imm_curr_ff};
			OFF_IMM_VOLT:  nxt_rdata = {16'h0000, imm_volt_ff};
			OFF_PEND_CURR: nxt_rdata = {16'h0000, pend_curr_ff};
			OFF_PEND_VOLT: nxt_rdata = {16'h0000, pend_volt_ff};
			OFF_ACT_CURR:  nxt_rdata = {16'h0000, act_curr_ff};
			OFF_ACT_VOLT:  nxt_rdata = {16'h0000, act_volt_ff};
			OFF_OPER:      nxt_rdata = {16'h0000, oper_ff};
			OFF_ESR:       nxt_rdata = {24'h00_0000, esr_ff};
			OFF_ESE:       nxt_rdata = {24'h00_0000, ese_ff};
			OFF_SRE:       nxt_rdata = {24'h00_0000, sre_ff};
			OFF_STB:       nxt_rdata = {24'h00_0000, stb};
			OFF_ERR_READ:  nxt_rdata = {8'h00, err_text(errq.head), errq.head};
			OFF_PORT:      nxt_rdata = {30'h0000_0000, port_ff};
			default:       nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ---------------- Commands ----------------
	assign wr_ctrl   = wr_fire && (awaddr_ff == OFF_CTRL) && wstrb_ff[0];
	assign cmd_arm   = wr_ctrl && wdata_ff[CTRL_ARM];
	assign cmd_fire  = wr_ctrl && wdata_ff[CTRL_FIRE];
	assign cmd_clear = wr_ctrl && wdata_ff[CTRL_CLEAR];
	assign cmd_abort = wr_ctrl && (wdata_ff[CTRL_CANCEL] || wdata_ff[CTRL_RECALL]
		|| wdata_ff[CTRL_RESET]);
	assign fire_ok   = cmd_fire && armed_ff && !cmd_abort;
	assign cont_on_write = wr_fire && (awaddr_ff == OFF_CONT) && wstrb_ff[0] && wdata_ff[0];
	assign nxt_imm_curr  = merge16(imm_curr_ff, wdata_ff, wstrb_ff);
	assign nxt_imm_volt  = merge16(imm_volt_ff, wdata_ff, wstrb_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cont_ff <= 1'b0;
		end else if (wr_fire && (awaddr_ff == OFF_CONT) && wstrb_ff[0]) begin
			cont_ff <= wdata_ff[0];
		end
	end

	// Reset leaves the cancelled state: unarmed, flag clear, nothing pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_ff      <= 1'b0;
			oper_ff       <= OPER_RESET;
			fire_trigger_cmd_pulse_ff <= 1'b0;
		end else begin
			fire_trigger_cmd_pulse_ff <= fire_ok;
			if (cmd_abort) begin
				armed_ff          <= cont_ff;
				oper_ff[OPER_WTG] <= cont_ff;
			end else if (fire_ok) begin
				oper_ff           <= OPER_RESET;
				oper_ff[OPER_WTG] <= cont_ff;
				armed_ff          <= cont_ff;
			end else if (cmd_arm || cont_on_write) begin
				armed_ff          <= 1'b1;
				oper_ff[OPER_WTG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			imm_curr_ff <= '0;
			imm_volt_ff <= '0;
		end else if (wr_fire && awaddr_ff == OFF_IMM_CURR) begin
			imm_curr_ff <= nxt_imm_curr;
		end else if (wr_fire && awaddr_ff == OFF_IMM_VOLT) begin
			imm_volt_ff <= nxt_imm_volt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_curr_ff  <= '0;
			pend_volt_ff  <= '0;
			pend_valid_ff <= 1'b0;
		end else if (cmd_abort) begin
			pend_curr_ff  <= imm_curr_ff;
			pend_volt_ff  <= imm_volt_ff;
			pend_valid_ff <= 1'b0;
		end else if (fire_ok) begin
			pend_valid_ff <= 1'b0;
		end else if (wr_fire && awaddr_ff == OFF_PEND_CURR) begin
			pend_curr_ff  <= merge16(pend_curr_ff, wdata_ff, wstrb_ff);
			pend_valid_ff <= 1'b1;
		end else if (wr_fire && awaddr_ff == OFF_PEND_VOLT) begin
			pend_volt_ff  <= merge16(pend_volt_ff, wdata_ff, wstrb_ff);
			pend_valid_ff <= 1'b1;
		end
	end

	// Immediate writes take effect at once; a trigger overrides them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_curr_ff <= '0;
			act_volt_ff <= '0;
		end else if (fire_ok && pend_valid_ff) begin
			act_curr_ff <= pend_curr_ff;
			act_volt_ff <= pend_volt_ff;
		end else if (wr_fire && awaddr_ff == OFF_IMM_CURR) begin
			act_curr_ff <= nxt_imm_curr;
		end else if (wr_fire && awaddr_ff == OFF_IMM_VOLT) begin
			act_volt_ff <= nxt_imm_volt;
		end
	end

	// ---------------- Error queue and event status ----------------
	assign errq.push      = wr_fire && (awaddr_ff == OFF_ERR_POST) && (wstrb_ff[1:0] == 2'b11);
	assign errq.push_code = wdata_ff[15:0];
	assign errq.pop       = rd_fire && (s_axi_araddr == OFF_ERR_READ);
	assign errq.flush     = cmd_clear;

	// New events win over a same-cycle read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			esr_ff <= ESR_RESET;
		end else begin
			esr_ff <= (((rd_fire && s_axi_araddr == OFF_ESR) || cmd_clear) ? 8'h00 : esr_ff)
				| (errq.push ? err_class(errq.push_code) : 8'h00)
				| (errq.overflow ? err_class(ERR_OVERFLOW) : 8'h00);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ese_ff <= MASK_RESET;
			sre_ff <= MASK_RESET;
		end else if (wr_fire && wstrb_ff[0]) begin
			if (awaddr_ff == OFF_ESE) begin
				ese_ff <= wdata_ff[7:0];
			end
			if (awaddr_ff == OFF_SRE) begin
				sre_ff <= wdata_ff[7:0];
			end
		end
	end

	// Summary bit is recomputed every cycle so it can never go stale
	always_comb begin
		stb                 = 8'h00;
		stb[STB_MAV]        = msg_pending;
		stb[STB_ESB]        = |(esr_ff & ese_ff);
		service_summary_bit = |(stb & sre_ff & ~(8'h01 << STB_MSS));
		stb[STB_MSS]        = service_summary_bit;
	end

	// ---------------- Port arbitration ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_meta_ff <= 2'b11;
			rx_sync_ff <= 2'b11;
			rx_prev_ff <= 2'b11;
		end else begin
			rx_meta_ff <= {rx_b, rx_a};
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
		end
	end

	// Start-bit edge marks traffic; idle line is high
	assign rx_start = rx_prev_ff & ~rx_sync_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_ff     <= port_none;
			idle_cnt_ff <= '0;
		end else begin
			unique case (port_ff)
				port_none: begin
					idle_cnt_ff <= '0;
					if (rx_start[0]) begin
						port_ff <= port_a;
					end else if (rx_start[1]) begin
						port_ff <= port_b;
					end
				end
				port_a, port_b: begin
					if (rx_start[port_ff == port_b]) begin
						idle_cnt_ff <= '0;
					end else if (idle_cnt_ff >= IDLE_CYCLES - 36'h0_0000_0001) begin
						port_ff     <= port_none;
						idle_cnt_ff <= '0;
					end else begin
						idle_cnt_ff <= idle_cnt_ff + 36'h0_0000_0001;
					end
				end
				default: port_ff <= port_none;
			endcase
		end
	end

	// Only the active port reaches the receiver; the other sees an idle line
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_sel_ff   <= 1'b1;
			baud_div_ff <= BAUD_DIV;
		end else begin
			baud_div_ff <= BAUD_DIV;
			unique case (port_ff)
				port_a:  rx_sel_ff <= rx_sync_ff[0];
				port_b:  rx_sel_ff <= rx_sync_ff[1];
				default: rx_sel_ff <= 1'b1;
			endcase
		end
	end

	assign active_current           = act_curr_ff;
	assign active_voltage           = act_volt_ff;
	assign trigger_pulse            = fire_trigger_cmd_pulse_ff;
	assign waiting_for_trigger_flag = oper_ff[OPER_WTG];
	assign port_active              = port_ff;
	assign rx_selected              = rx_sel_ff;
	assign uart_baud_div            = baud_div_ff;

endmodule : rtsl_top

// File: tb_remote_trigger_status_logic.sv
`timescale 1ns/1ps
module tb_remote_trigger_status_logic;
	import rtsl_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, msg_pending = 1'b0, rx_a, rx_b, trigger_pulse;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic waiting_for_trigger_flag, service_summary_bit, rx_selected;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] active_current, active_voltage, uart_baud_div;
	rtsl_port_t port_active;
	logic [15:0] codes [4] = '{ERR_CMD, ERR_RANGE, ERR_OVERFLOW, ERR_QUERY};
	logic [7:0] txts [4] = '{TXT_CMD, TXT_RANGE, TXT_OVERFLOW, TXT_QUERY};
	int cls [4] = '{5, 4, 3, 2};
	int error_cnt = 0;
	int samples_checked = 0;
	// Shortened release count of 65536 cycles lets port A drop before the run ends
	rtsl_top #(.IDLE_CYCLES(36'h0_0001_0000)) uut (.*);
	rtsl_host ha (.rx_line(rx_a));
	rtsl_host hb (.rx_line(rx_b));
	initial forever #5 aclk = ~aclk;
	task automatic give_verdict;
		$display("checks %0d bad %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic acc(input bit w, input logic [7:0] a, input logic [23:0] d, input logic [1:0] er = 2'h0);
		int n;
		logic aw_hs, w_hs, ar_hs, done;
		logic [33:0] seen;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 8'h00, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
		done = 1'b0;
		seen = '0;
		// Handshakes are judged on settled values, then the edge that moves them passes
		for (n = 0; n < 50 && !done; n++) begin
			#1;
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs  = s_axi_wvalid && s_axi_wready;
			ar_hs = s_axi_arvalid && s_axi_arready;
			done  = w ? s_axi_bvalid : s_axi_rvalid;
			seen  = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
			@(posedge aclk);
			if (aw_hs) s_axi_awvalid <= 1'b0;
			if (w_hs) s_axi_wvalid <= 1'b0;
			if (ar_hs) s_axi_arvalid <= 1'b0;
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
		if (!done) begin
			error_cnt++;
			give_verdict();
		end
		chk($sformatf("@%h", a), seen, {er, w ? 32'h0 : {8'h00, d}});
	endtask : acc
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		acc(0, OFF_ESR, 24'h00_0080);
		acc(0, OFF_ESR, 24'h00_0000);
		acc(0, 8'h40, 24'h00_0000, 2'h2);
		acc(1, OFF_PEND_CURR, 24'h00_1234);
		acc(1, OFF_CTRL, 24'h00_0002);
		acc(0, OFF_ACT_CURR, 24'h00_0000);
		acc(1, OFF_CTRL, 24'h00_0001);
		acc(0, OFF_OPER, 24'h00_0020);
		acc(1, OFF_CTRL, 24'h00_0002);
		acc(0, OFF_OPER, 24'h00_0000);
		acc(1, OFF_PEND_CURR, 24'h00_0abc);
		// Second fire without a fresh arm must leave levels alone
		acc(1, OFF_CTRL, 24'h00_0002);
		acc(0, OFF_ACT_CURR, 24'h00_1234);
		acc(1, OFF_CONT, 24'h00_0001);
		acc(0, OFF_CONT, 24'h00_0001);
		acc(1, OFF_CTRL, 24'h00_0002);
		acc(0, OFF_OPER, 24'h00_0020);
		acc(1, OFF_CTRL, 24'h00_0004);
		acc(0, OFF_OPER, 24'h00_0020);
		acc(1, OFF_PEND_CURR, 24'h00_0777);
		acc(1, OFF_CONT, 24'h00_0000);
		acc(1, OFF_CTRL, 24'h00_0008);
		acc(0, OFF_PEND_CURR, 24'h00_0000);
		acc(0, OFF_OPER, 24'h00_0000);
		$display("trigger tests done");
		for (int i = 0; i < 4; i++) begin
			acc(1, OFF_ERR_POST, {8'h00, codes[i]});
			acc(0, OFF_ESR, 24'h00_0001 << cls[i]);
		end
		for (int i = 0; i < 4; i++) acc(0, OFF_ERR_READ, {txts[i], codes[i]});
		for (int i = 0; i < 9; i++) acc(1, OFF_ERR_POST, {8'h00, ERR_CMD});
		for (int i = 0; i < 9; i++) acc(0, OFF_ERR_READ, i < 7 ? 24'h01_ff9c : i < 8 ? 24'h05_fea2 : 24'h00_0000);
		$display("error tests done");
		acc(1, OFF_SRE, 24'h00_0010);
		msg_pending <= 1'b1;
		acc(0, OFF_STB, 24'h00_0050);
		chk("summary", {33'h0, service_summary_bit}, 34'h1);
		acc(1, OFF_ESE, 24'h00_0008);
		msg_pending <= 1'b0;
		acc(1, OFF_SRE, 24'h00_0020);
		acc(0, OFF_STB, 24'h00_0060);
		$display("status tests done");
		fork
			ha.send(8'h00);
			#2000 hb.send(8'h00);
		join
		chk("port", {32'h0, port_active}, {32'h0, port_a});
		// Past the shortened release count with no traffic the selection must drop
		repeat (20000) @(posedge aclk);
		chk("release", {32'h0, port_active}, {32'h0, port_none});
		$display("port tests done");
		give_verdict();
	end
endmodule : tb_remote_trigger_status_logic
